// ### afc_adc_ctrl.sv
// Converter control top: AHB-Lite registers, sequencer, SAR, pin setup
//
// The AHB-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
module afc_adc_ctrl #(
	parameter bit EXT_CFG = 1'b0
) (
	input wire logic MCLK_I,
	input wire logic RST_I,
	input wire logic CE_I,
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	output logic [31:0] HRDATA_O,
	output logic HREADYOUT_O,
	output logic HRESP_O,
	input wire logic SLEEP_I,
	input wire logic RC_OSC_I,
	input wire logic COMP_I,
	input wire logic [3:0] PORT_PIN_I,
	output logic CONV_ON_O,
	output logic [1:0] CHAN_SEL_O,
	output logic SAMPLE_O,
	output logic [7:0] DAC_O,
	output afc_pkg::afc_ref_e REF_SEL_O,
	output logic [3:0] PIN_ANALOG_O
);
	import afc_pkg::*;

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	logic wr_pend_r;
	logic rd_pend_r;
	logic [7:0] addr_r;
	logic [31:0] rdata_r;
	logic [31:0] rd_mux;
	logic take;
	logic we_ctrl;
	logic we_pcfg;
	logic we_res;
	logic [7:0] wd;

	// Control and data state
	logic [1:0] cs_r;
	logic [1:0] ch_r;
	logic en_r;
	logic go_r;
	logic flag_r;
	logic [2:0] pcfg_r;
	logic [7:0] res_r;
	logic [7:0] sar_r;
	logic [3:0] cnt_r;
	afc_state_e st_r;
	logic [3:0] an_mask_r;
	afc_ref_e ref_r;
	logic [2:0] pin_sync_r [4];
	logic [3:0] pin_lvl_r;

	logic tick;
	logic start;
	logic abort;
	logic done_evt;
	logic [2:0] bitpos;

	assign take = HSEL_I && HREADY_I && HTRANS_I[1];
	assign wd = HWDATA_I[7:0];
	assign we_ctrl = wr_pend_r && addr_r == ADDR_CTRL;
	assign we_pcfg = wr_pend_r && addr_r == ADDR_PCFG;
	assign we_res = wr_pend_r && addr_r == ADDR_RES;

	// Writes finish with no wait; reads take one wait state
	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			addr_r <= 8'h00;
		end else if (CE_I) begin
			if (rd_pend_r) begin
				rd_pend_r <= 1'b0;
				wr_pend_r <= 1'b0;
			end else begin
				wr_pend_r <= take && HWRITE_I;
				rd_pend_r <= take && !HWRITE_I;
				if (take)
					addr_r <= HADDR_I[7:0];
			end
		end
	end

	// Unmapped and unimplemented bits read zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (addr_r)
			ADDR_CTRL: rd_mux[7:0] = {cs_r, 1'b0, ch_r, go_r, flag_r,
				en_r};
			ADDR_PCFG: rd_mux[2:0] = pcfg_r;
			ADDR_RES: rd_mux[7:0] = res_r;
			ADDR_PORT: rd_mux[3:0] = pin_lvl_r & ~an_mask_r;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I)
			rdata_r <= 32'h0000_0000;
		else if (CE_I && rd_pend_r)
			rdata_r <= rd_mux;
	end

	assign HRDATA_O = rdata_r;
	assign HREADYOUT_O = !rd_pend_r;
	assign HRESP_O = 1'b0;

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			cs_r <= CS_RST;
			ch_r <= CH_RST;
			en_r <= 1'b0;
		end else if (CE_I && we_ctrl) begin
			cs_r <= wd[CS_LO +: 2];
			ch_r <= wd[CH_LO +: 2];
			en_r <= wd[EN_BIT];
		end
	end

	// Hardware set wins over a software clear in the same cycle
	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I)
			flag_r <= 1'b0;
		else if (CE_I) begin
			if (done_evt)
				flag_r <= 1'b1;
			else if (we_ctrl)
				flag_r <= wd[FLAG_BIT];
		end
	end

	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I)
			pcfg_r <= PCFG_RST;
		else if (CE_I && we_pcfg)
			pcfg_r <= wd[2:0] & (EXT_CFG ? PCFG_MASK3[2:0] :
				PCFG_MASK2[2:0]);
	end

	// Completion load beats a software write of the result
	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I)
			res_r <= RES_RST;
		else if (CE_I) begin
			if (done_evt)
				res_r <= sar_r;
			else if (we_res)
				res_r <= wd;
		end
	end

	// ----------------------------------------
	// Pin configuration and reference
	// ----------------------------------------
	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			an_mask_r <= 4'hf;
			ref_r <= REF_SUPPLY;
		end else if (CE_I) begin
			an_mask_r <= cfg_analog(pcfg_r, EXT_CFG);
			ref_r <= cfg_ref(pcfg_r, EXT_CFG);
		end
	end

	// Decoder covers both widths of the field
	assign PIN_ANALOG_O = an_mask_r;
	assign REF_SEL_O = ref_r;

	// Digital pin levels: three flops, move once last two agree
	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			for (int i = 0; i < 4; i++)
				pin_sync_r[i] <= 3'h0;
			pin_lvl_r <= 4'h0;
		end else if (CE_I) begin
			for (int i = 0; i < 4; i++) begin
				pin_sync_r[i] <= {pin_sync_r[i][1:0], PORT_PIN_I[i]};
				if (pin_sync_r[i][1] == pin_sync_r[i][2])
					pin_lvl_r[i] <= pin_sync_r[i][2];
			end
		end
	end

	// ----------------------------------------
	// Bit-period source
	// ----------------------------------------
	afc_tad_gen u_tad (
		.clk_i(MCLK_I),
		.rst_i(RST_I),
		.ce_i(CE_I),
		.sel_i(cs_r),
		.clr_i(start || abort),
		.sleep_i(SLEEP_I),
		.rc_i(RC_OSC_I),
		.tick_o(tick)
	);

	// ----------------------------------------
	// Conversion sequencer
	// ----------------------------------------
	assign start = we_ctrl && wd[GO_BIT] && en_r && st_r == ST_ACQ;
	assign abort = we_ctrl && !wd[GO_BIT] && st_r == ST_CONV;
	assign done_evt = st_r == ST_CONV && tick && cnt_r == CONV_LAST &&
		!abort && en_r;
	assign bitpos = 3'(4'h8 - cnt_r);

	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			st_r <= ST_OFF;
			go_r <= 1'b0;
			cnt_r <= 4'h0;
		end else if (CE_I) begin
			if (!en_r) begin
				st_r <= ST_OFF;
				go_r <= 1'b0;
				cnt_r <= 4'h0;
			end else begin
				unique case (st_r)
					ST_OFF: st_r <= ST_ACQ;
					ST_ACQ: if (start) begin
						st_r <= ST_CONV;
						go_r <= 1'b1;
						cnt_r <= 4'h0;
					end
					ST_CONV: if (abort) begin
						st_r <= ST_HOLD;
						go_r <= 1'b0;
						cnt_r <= 4'h0;
					end else if (tick) begin
						if (cnt_r == CONV_LAST) begin
							st_r <= ST_HOLD;
							go_r <= 1'b0;
							cnt_r <= 4'h0;
						end else
							cnt_r <= cnt_r + 4'h1;
					end
					ST_HOLD: if (tick) begin
						if (cnt_r == HOLD_LAST) begin
							st_r <= ST_ACQ;
							cnt_r <= 4'h0;
						end else
							cnt_r <= cnt_r + 4'h1;
					end
				endcase
			end
		end
	end

	// One comparator decision per bit period for counts 1 to 8 of the 10, MSB first
	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I)
			sar_r <= SAR_FIRST;
		else if (CE_I) begin
			if (start)
				sar_r <= SAR_FIRST;
			else if (st_r == ST_CONV && tick && cnt_r >= 4'h1 &&
				cnt_r <= 4'h8) begin
				sar_r[bitpos] <= COMP_I;
				if (bitpos != 3'h0)
					sar_r[bitpos - 3'h1] <= 1'b1;
			end
		end
	end

	// Capacitor only connected while acquiring; never discharged
	assign SAMPLE_O = st_r == ST_ACQ;
	assign CONV_ON_O = en_r;
	assign CHAN_SEL_O = ch_r;
	assign DAC_O = sar_r;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	// Ticks counted apart from cnt_r, for the length check
	logic [3:0] conv_ticks_r;

	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I)
			conv_ticks_r <= 4'h0;
		else if (CE_I) begin
			if (start)
				conv_ticks_r <= 4'h0;
			else if (st_r == ST_CONV && tick && conv_ticks_r != 4'hf)
				conv_ticks_r <= conv_ticks_r + 4'h1;
		end
	end

	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (RST_I || !CE_I);

	a_start_sets_go: assert property (
		start |=> go_r && st_r == ST_CONV)
		else $error("start did not set go");
	a_done_clears_go: assert property (
		done_evt |=> !go_r && flag_r)
		else $error("completion left go set");
	a_flag_sticky: assert property (
		flag_r && !we_ctrl |=> flag_r)
		else $error("completion flag dropped by hardware");
	a_off_no_start: assert property (
		!en_r ##1 !en_r |-> !go_r && st_r == ST_OFF)
		else $error("disabled converter busy");
	a_pcfg_upper_zero: assert property (
		rd_pend_r && addr_r == ADDR_PCFG |=> HRDATA_O[31:3] == 29'h0)
		else $error("unimplemented bits read nonzero");
	a_result_load: assert property (
		done_evt |=> res_r == $past(sar_r))
		else $error("result not loaded at completion");
	a_conv_length: assert property (
		done_evt |-> conv_ticks_r == CONV_LAST)
		else $error("conversion length wrong");
	a_hold_apart: assert property (
		done_evt |=> !SAMPLE_O [*4])
		else $error("capacitor reconnected too early");
	a_abort_keeps: assert property (
		abort |=> res_r == $past(res_r) &&
		flag_r == $past(wd[FLAG_BIT]))
		else $error("abort disturbed result");
	a_analog_read: assert property (
		rd_pend_r && addr_r == ADDR_PORT |=> (HRDATA_O[3:0] &
		$past(an_mask_r)) == 4'h0)
		else $error("analog pin read nonzero");

	c_done: cover property (done_evt);
	c_abort: cover property (abort);
	c_reacquire: cover property (st_r == ST_HOLD ##1 st_r == ST_ACQ);
	c_sleep_done: cover property (SLEEP_I && done_evt);

endmodule : afc_adc_ctrl

// ### afc_front_model.sv
// Analog front end model: four inputs, holding capacitor, comparator
`timescale 1ns/100ps
module afc_front_model (
	input wire logic clk_i,
	input wire logic [31:0] level_i,
	input wire logic [1:0] chan_i,
	input wire logic sample_i,
	input wire logic [7:0] dac_i,
	output logic comp_o
);
	// ----------------------------------------
	// Holding capacitor and comparator
	// ----------------------------------------
	logic [7:0] hold_r = 8'h00;

	// Charge kept while disconnected, never discharged
	always @(posedge clk_i) begin
		if (sample_i) begin
			hold_r <= level_i[chan_i * 8 +: 8];
		end
	end

	assign comp_o = (hold_r >= dac_i);
endmodule : afc_front_model

// ### afc_pkg.sv
// Package: constants, types and decoders of the converter control block
//
// How it works
// - Clock select bits 7:6 pick bit period: sysclk/2, /8, /32, or RC.
// - Channel select bits 4:3 route input 0 to 3 to sample and hold.
// - Writing one to go bit while enabled starts; reads one while busy.
// - Hardware clears go bit when the conversion completes.
// - Completion flag bit 1 set at finish, cleared only by software.
// - Enable bit 0 powers converter; when clear, start requests ignored.
// - Unimplemented bits read zero and ignore writes.
// - Two-bit pin field sets pins analog, reference or digital.
// - Two-bit mode: reference is input 3 when configured so, else supply.
// - Three-bit pin field decodes eight analog/digital/reference patterns.
// - Three-bit mode: reference is input 1 when configured so, else supply.
// - Reset forces all shared pins analog and control fields to zero.
// - Result loads in same step as go clear and flag set.
// - Conversion lasts 10 bit periods, one decision per result bit.
// - After completion wait 2 bit periods disconnected, then acquire.
// - Holding capacitor is never discharged between conversions.
// - Converter completes conversions in sleep when run from RC clock.
// - Clearing go mid-conversion aborts, keeps result, reacquires after 2 periods.
// - Port data reads zero for pins configured analog.
package afc_pkg;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_PCFG = 8'h04;
	localparam logic [7:0] ADDR_RES = 8'h08;
	localparam logic [7:0] ADDR_PORT = 8'h0c;

	// ----------------------------------------
	// Field positions and masks
	// ----------------------------------------
	localparam int CS_LO = 6;
	localparam int CH_LO = 3;
	localparam int GO_BIT = 2;
	localparam int FLAG_BIT = 1;
	localparam int EN_BIT = 0;
	localparam logic [7:0] PCFG_MASK2 = 8'h03;
	localparam logic [7:0] PCFG_MASK3 = 8'h07;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [1:0] CS_RST = 2'h0;
	localparam logic [1:0] CH_RST = 2'h0;
	localparam logic [2:0] PCFG_RST = 3'h0;
	localparam logic [7:0] RES_RST = 8'h00;
	localparam logic [7:0] SAR_FIRST = 8'h80;

	// ----------------------------------------
	// Cycle counts
	// ----------------------------------------
	localparam logic [4:0] DIV2_TC = 5'h01;
	localparam logic [4:0] DIV8_TC = 5'h07;
	localparam logic [4:0] DIV32_TC = 5'h1f;
	localparam logic [3:0] CONV_LAST = 4'h9;
	localparam logic [3:0] HOLD_LAST = 4'h1;

	typedef enum logic [1:0] {REF_SUPPLY, REF_PIN3, REF_PIN1} afc_ref_e;
	typedef enum logic [1:0] {ST_OFF, ST_ACQ, ST_CONV, ST_HOLD} afc_state_e;

	// Pins not configured digital (analog or reference)
	function automatic logic [3:0] cfg_analog(input logic [2:0] c,
		input logic ext);
		logic [3:0] m;
		m = 4'h0;
		if (ext) begin
			unique case (c)
				3'h0, 3'h1: m = 4'hf;
				3'h2, 3'h3: m = 4'h7;
				3'h4, 3'h5: m = 4'h3;
				3'h6: m = 4'h1;
				3'h7: m = 4'h0;
			endcase
		end else begin
			unique case (c[1:0])
				2'h0, 2'h1: m = 4'hf;
				2'h2: m = 4'h3;
				2'h3: m = 4'h0;
			endcase
		end
		return m;
	endfunction : cfg_analog

	function automatic afc_ref_e cfg_ref(input logic [2:0] c,
		input logic ext);
		afc_ref_e r;
		r = REF_SUPPLY;
		if (ext && c[0] && c != 3'h7)
			r = REF_PIN1;
		else if (!ext && c[1:0] == 2'h1)
			r = REF_PIN3;
		return r;
	endfunction : cfg_ref

endpackage : afc_pkg

// ### afc_tad_gen.sv
// Bit-period tick generator: system clock divider or RC oscillator edges
`timescale 1ns/100ps
module afc_tad_gen (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [1:0] sel_i,
	input wire logic clr_i,
	input wire logic sleep_i,
	input wire logic rc_i,
	output logic tick_o
);
	import afc_pkg::*;

	logic [4:0] div_r;
	logic [4:0] tc;
	logic [2:0] rc_sync_r;
	logic rc_lvl_r;
	logic rc_edge;

	always_comb begin
		unique case (sel_i)
			2'h0: tc = DIV2_TC;
			2'h1: tc = DIV8_TC;
			default: tc = DIV32_TC;
		endcase
	end

	// RC pin: three flops, level moves once the last two agree
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rc_sync_r <= 3'h0;
			rc_lvl_r <= 1'b0;
		end else if (ce_i) begin
			rc_sync_r <= {rc_sync_r[1:0], rc_i};
			if (rc_sync_r[1] == rc_sync_r[2])
				rc_lvl_r <= rc_sync_r[2];
		end
	end

	assign rc_edge = rc_sync_r[1] == rc_sync_r[2] && rc_sync_r[2] &&
		!rc_lvl_r;

	// Divider restarts on clear so the first period is whole
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			div_r <= 5'h00;
		else if (ce_i) begin
			if (clr_i || div_r >= tc)
				div_r <= 5'h00;
			else
				div_r <= div_r + 5'h01;
		end
	end

	// Core clock stops in sleep; only the RC source keeps ticking
	always_comb begin
		if (sel_i == 2'h3)
			tick_o = rc_edge;
		else
			tick_o = !sleep_i && !clr_i && div_r >= tc;
	end

endmodule : afc_tad_gen

// ### tb.sv
// Self-checking testbench of the converter control block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; \
	if ((g) !== (e)) begin errors++; \
	$display("unexpected %s exp %0h got %0h", nm, e, g); end end
module tb;
	import afc_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic mclk = 1'b0, rst = 1'b1, rc = 1'b0, sleep = 1'b0;
	logic hsel = 1'b0, hwrite = 1'b0, ready, hresp, comp, conv_on, sample;
	logic [1:0] htrans = 2'b00, chan;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
	logic [31:0] level = 32'hff00_807f, rd;
	logic [3:0] pins = 4'h0, pin_an, pin_an3;
	logic [7:0] dac, last_res;
	afc_ref_e ref_sel, ref_sel3, exp_ref;
	int errors = 0, cmp_count = 0, seed = 32'h8bce;

	always #25 mclk = ~mclk;
	initial #37 forever #200 rc = ~rc;

	afc_adc_ctrl #(.EXT_CFG(1'b0)) i_dut (.MCLK_I(mclk), .RST_I(rst),
		.CE_I(1'b1), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
		.HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
		.HREADY_I(ready), .HRDATA_O(hrdata), .HREADYOUT_O(ready),
		.HRESP_O(hresp), .SLEEP_I(sleep), .RC_OSC_I(rc), .COMP_I(comp),
		.PORT_PIN_I(pins), .CONV_ON_O(conv_on), .CHAN_SEL_O(chan),
		.SAMPLE_O(sample), .DAC_O(dac), .REF_SEL_O(ref_sel),
		.PIN_ANALOG_O(pin_an));

	// Three-bit pin field variant on the same bus, decode checks only
	afc_adc_ctrl #(.EXT_CFG(1'b1)) i_dut_ext (.MCLK_I(mclk), .RST_I(rst),
		.CE_I(1'b1), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
		.HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
		.HREADY_I(ready), .HRDATA_O(), .HREADYOUT_O(), .HRESP_O(),
		.SLEEP_I(sleep), .RC_OSC_I(rc), .COMP_I(comp),
		.PORT_PIN_I(pins), .CONV_ON_O(), .CHAN_SEL_O(), .SAMPLE_O(),
		.DAC_O(), .REF_SEL_O(ref_sel3), .PIN_ANALOG_O(pin_an3));

	afc_front_model i_front (.clk_i(mclk), .level_i(level), .chan_i(chan),
		.sample_i(sample), .dac_i(dac), .comp_o(comp));

	// ----------------------------------------
	// Closing, bus and expectation helpers
	// ----------------------------------------
	task automatic close_out;
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out

	// Ready seen stable before the edge that samples it
	task automatic wait_rdy;
		int n;
		n = 0;
		@(negedge mclk);
		while (ready !== 1'b1 && n < 64) begin
			@(negedge mclk);
			n++;
		end
		if (n == 64) begin
			errors++;
			close_out();
		end
		rd = hrdata;
		@(posedge mclk);
	endtask : wait_rdy

	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'b10;
		hwrite <= w;
		wait_rdy();
		htrans <= 2'b00;
		hwdata <= wd;
		wait_rdy();
	endtask : bus

	function automatic logic [3:0] exp_an(input logic [1:0] c);
		return (c == 2'h2) ? 4'h3 : (c == 2'h3) ? 4'h0 : 4'hf;
	endfunction : exp_an

	function automatic logic [3:0] exp_an3(input logic [2:0] c);
		return (c < 3'h2) ? 4'hf : (c < 3'h4) ? 4'h7 :
			(c < 3'h6) ? 4'h3 : (c == 3'h6) ? 4'h1 : 4'h0;
	endfunction : exp_an3

	task automatic wait_sample;
		int n;
		n = 0;
		while (sample !== 1'b1 && n < 3000) begin
			@(negedge mclk);
			n++;
		end
		if (n == 3000) begin
			errors++;
			close_out();
		end
		rd = n;
		@(posedge mclk);
	endtask : wait_sample

	task automatic conv(input logic [1:0] cs, input logic [1:0] ch);
		logic [7:0] v;
		int d;
		int s;
		v = level[ch * 8 +: 8];
		d = 2 << (2 * cs);
		bus(1'b1, ADDR_CTRL, {24'h00_0000, cs, 1'b0, ch, 3'h1});
		@(negedge mclk);
		`CHK("chan", ch, chan)
		repeat (40) @(posedge mclk);
		bus(1'b1, ADDR_CTRL, {24'h00_0000, cs, 1'b0, ch, 3'h5});
		bus(1'b0, ADDR_CTRL, 32'h0000_0000);
		`CHK("go busy", 1'b1, rd[GO_BIT])
		wait_sample();
		s = rd + 4 - 12 * d;
		if (cs != 2'h3)
			`CHK("span", 1'b1, s >= -3 && s <= 3)
		bus(1'b0, ADDR_CTRL, 32'h0000_0000);
		`CHK("go done", 1'b0, rd[GO_BIT])
		`CHK("flag set", 1'b1, rd[FLAG_BIT])
		bus(1'b0, ADDR_RES, 32'h0000_0000);
		`CHK("result", {24'h00_0000, v}, rd)
		last_res = v;
		bus(1'b1, ADDR_CTRL, {24'h00_0000, cs, 1'b0, ch, 3'h1});
		bus(1'b0, ADDR_CTRL, 32'h0000_0000);
		`CHK("flag clr", 1'b0, rd[FLAG_BIT])
	endtask : conv

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		pins <= 4'($random(seed));
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		`CHK("pins rst", 4'hf, pin_an)
		for (int a = 0; a < 5; a++) begin
			bus(1'b0, 8'(a * 4), 32'h0000_0000);
			`CHK("reg rst", 32'h0000_0000, rd)
		end
		bus(1'b1, ADDR_PCFG, 32'hffff_ffff);
		bus(1'b0, ADDR_PCFG, 32'h0000_0000);
		`CHK("pcfg bits", 32'h0000_0003, rd)
		bus(1'b1, ADDR_CTRL, 32'h0000_00ff);
		bus(1'b0, ADDR_CTRL, 32'h0000_0000);
		`CHK("bit5", 1'b0, rd[5])
		`CHK("go with en", 1'b0, rd[GO_BIT])
		bus(1'b1, ADDR_CTRL, 32'h0000_0000);
		for (int c = 0; c < 8; c++) begin
			bus(1'b1, ADDR_PCFG, 32'(c));
			repeat (2) @(posedge mclk);
			`CHK("analog", exp_an(2'(c)), pin_an)
			exp_ref = (c % 4 == 1) ? REF_PIN3 : REF_SUPPLY;
			`CHK("ref", exp_ref, ref_sel)
			`CHK("analog3", exp_an3(3'(c)), pin_an3)
			exp_ref = (c % 2 == 1 && c != 7) ? REF_PIN1 : REF_SUPPLY;
			`CHK("ref3", exp_ref, ref_sel3)
			bus(1'b0, ADDR_PORT, 32'h0000_0000);
			`CHK("port", {28'h000_0000, pins & ~exp_an(2'(c))}, rd)
		end
		bus(1'b1, ADDR_PCFG, 32'h0000_0000);
		for (int k = 0; k < 9; k++) begin
			if (k >= 4)
				level <= $random(seed);
			@(posedge mclk);
			conv(2'(k % 3), 2'(k % 4));
		end
		sleep <= 1'b1;
		conv(2'h3, 2'h2);
		sleep <= 1'b0;
		bus(1'b1, ADDR_CTRL, 32'h0000_0004);
		bus(1'b0, ADDR_CTRL, 32'h0000_0000);
		`CHK("go off", 1'b0, rd[GO_BIT])
		`CHK("power", 1'b0, conv_on)
		level <= ~level;
		bus(1'b1, ADDR_CTRL, 32'h0000_0089);
		repeat (40) @(posedge mclk);
		bus(1'b1, ADDR_CTRL, 32'h0000_008d);
		bus(1'b1, ADDR_CTRL, 32'h0000_0089);
		wait_sample();
		bus(1'b0, ADDR_RES, 32'h0000_0000);
		`CHK("abort res", {24'h00_0000, last_res}, rd)
		bus(1'b0, ADDR_CTRL, 32'h0000_0000);
		`CHK("abort flag", 1'b0, rd[FLAG_BIT])
		bus(1'b1, ADDR_PCFG, 32'h0000_0003);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		`CHK("pins rerst", 4'hf, pin_an)
		rst <= 1'b0;
		@(posedge mclk);
		bus(1'b0, ADDR_CTRL, 32'h0000_0000);
		`CHK("ctrl rerst", 32'h0000_0000, rd)
		`CHK("resp", 1'b0, hresp)
		close_out();
	end
endmodule : tb
